/* design/tid_pkg.sv */
// Notes on behaviour
// - Every trigger input offers normal edge, inverted edge, normal pulse, inverted pulse.
// - After reset every input works as normal edge.
// - Each input keeps its own control type setting.
// - An input drives a chosen set of functions; each action hits all of them.
// - Normal edge: falling edge switches each assigned function on.
// - Normal edge: rising edge switches two-state functions off.
// - Single-action functions such as mark or offset ignore the inactive edge.
// - Injection valve: falling edge selects load, rising edge selects inject.
// - Detector start/stop: falling edge starts, rising edge stops.
// - Inverted edge equals normal edge with rising and falling roles swapped.
// - Normal pulse: falling edge is active, rising edge ignored.
// - Pulse types: active pulse of 50 ms or more is always accepted.
// - Pulse types: active pulse of 4 ms or less is always rejected.
// - Inverted pulse: rising edge active, falling edge ignored.
package tid_pkg;

  // ---------------------------------------------------------------
  // Control types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TID_NORMAL_EDGE = 2'h0,
    TID_INVERTED_EDGE = 2'h1,
    TID_NORMAL_PULSE = 2'h2,
    TID_INVERTED_PULSE = 2'h3
  } tid_mode_type;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ = 125000;
  localparam int REJECT_MS = 4;
  localparam int DETECT_MS = 50;
  localparam int ACCEPT_MS = 20;
  localparam int REJECT_CYC = REJECT_MS * CLK_KHZ;
  localparam int DETECT_CYC = DETECT_MS * CLK_KHZ;
  localparam int ACCEPT_CYC = ACCEPT_MS * CLK_KHZ;
  localparam int CLAMP_MARGIN = 16;

  // ---------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] WORD_MODE = 4'h0;
  localparam logic [3:0] WORD_THRESH = 4'h1;
  localparam logic [3:0] WORD_KIND = 4'h2;
  localparam logic [3:0] WORD_STATUS = 4'h3;
  localparam logic [3:0] WORD_ASSIGN = 4'h4;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] KIND_RST = 32'h0000_00C0;
  localparam logic [31:0] ASSIGN_RST = 32'h0000_0000;
  localparam logic SYNC_RST = 1'b1;

  // ---------------------------------------------------------------
  // Function bit positions
  // ---------------------------------------------------------------
  localparam int FN_LEFT_INJECTION_VALVE = 0;
  localparam int FN_RIGHT_INJECTION_VALVE = 1;
  localparam int FN_TRAY_HIGH_PRESSURE_VALVE_A = 2;
  localparam int FN_TRAY_HIGH_PRESSURE_VALVE_B = 3;
  localparam int FN_REAR_LOW_PRESSURE_VALVE_A = 4;
  localparam int FN_DETECTOR_RUN = 5;
  localparam int FN_DETECTOR_MARK = 6;
  localparam int FN_DETECTOR_AUTO_OFFSET = 7;

endpackage

/* design/tid_chan_if.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Link between the register core and one input decoder
// ---------------------------------------------------------------
interface tid_chan_if #(parameter int CNT_W = 23);
  tid_pkg::tid_mode_type mode;
  logic [CNT_W-1:0] thresh;
  logic on_evt;
  logic off_evt;
  logic level;
  modport chan (input mode, input thresh, output on_evt, output off_evt, output level);
  modport ctl (output mode, output thresh, input on_evt, input off_evt, input level);
endinterface

/* design/tid_chan.sv */
`timescale 1ns/1ps
module tid_chan #(
  parameter int CNT_W = 23
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic pin_in,
  tid_chan_if.chan ch
);

  logic sync1_r, sync2_r, prev_r, armed_r, fired_r;
  logic armed_nxt, fired_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;

  // ---------------------------------------------------------------
  // Edge and pulse decode
  // ---------------------------------------------------------------
  wire fall = prev_r & ~sync2_r;
  wire rise = ~prev_r & sync2_r;
  wire is_pulse = ch.mode[1];
  wire swapped = ch.mode[0];
  wire act_edge = swapped ? rise : fall;
  wire idle_edge = swapped ? fall : rise;
  wire cnt_full = &cnt_r;
  wire pulse_hit = is_pulse & armed_r & ~fired_r & (cnt_r >= ch.thresh);

  // Events toward the function core
  assign ch.on_evt = ce_in & (is_pulse ? pulse_hit : act_edge);
  assign ch.off_evt = ce_in & ~is_pulse & idle_edge;
  assign ch.level = sync2_r;

  // Width measurement, restarted by the active edge
  assign armed_nxt = act_edge | (armed_r & ~idle_edge);
  assign fired_nxt = ~act_edge & ~idle_edge & (fired_r | pulse_hit);
  assign cnt_nxt = act_edge ? '0 : (armed_r & ~fired_r & ~cnt_full) ? cnt_r + 1'b1 : cnt_r;

  // Synchroniser; idles high so reset gives no edge
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_r <= tid_pkg::SYNC_RST;
      sync2_r <= tid_pkg::SYNC_RST;
      prev_r <= tid_pkg::SYNC_RST;
    end else if (ce_in) begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Pulse state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      armed_r <= 1'b0;
      fired_r <= 1'b0;
      cnt_r <= '0;
    end else if (ce_in) begin
      armed_r <= armed_nxt;
      fired_r <= fired_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_two_live;
    $past(ce_in) && $past(ce_in, 2) && $past(rst_n_in) && $past(rst_n_in, 2);
  endsequence

  a_sync_two_stage: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_two_live |-> ch.level == $past(pin_in, 2)) else $error("sync depth wrong");
  a_edge_on_fall: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && ch.mode == tid_pkg::TID_NORMAL_EDGE && fall) |-> ch.on_evt) else $error("fall missed");
  a_edge_off_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && ch.mode == tid_pkg::TID_NORMAL_EDGE && rise) |-> ch.off_evt && !ch.on_evt)
    else $error("rise missed");
  a_inv_edge_swap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && ch.mode == tid_pkg::TID_INVERTED_EDGE && rise) |-> ch.on_evt) else $error("swap wrong");
  a_pulse_no_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    is_pulse |-> !ch.off_evt && !(ch.on_evt && act_edge)) else $error("pulse edge acted");
  a_short_rejected: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (is_pulse && ch.on_evt) |-> cnt_r >= ch.thresh && armed_r) else $error("short pulse taken");

endmodule

/* design/tid_top.sv */
`timescale 1ns/1ps
module tid_top #(
  parameter int NUM_IN = 8,
  parameter int NUM_FUNC = 8,
  parameter int CNT_W = 23,
  parameter int ACCEPT_CYCLES = tid_pkg::ACCEPT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [NUM_IN-1:0] trig_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [NUM_FUNC-1:0] func_state_out,
  output logic [NUM_FUNC-1:0] func_act_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Merge write data into old value by byte lanes
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Keep threshold strictly between reject and detect widths
  function automatic logic [CNT_W-1:0] clamp_thr(
    input logic [31:0] v
  );
    logic [31:0] lo;
    logic [31:0] hi;
    lo = 32'(tid_pkg::REJECT_CYC + tid_pkg::CLAMP_MARGIN);
    hi = 32'(tid_pkg::DETECT_CYC - tid_pkg::CLAMP_MARGIN);
    if (v < lo) begin
      return CNT_W'(lo);
    end else if (v > hi) begin
      return CNT_W'(hi);
    end
    return CNT_W'(v);
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [2*NUM_IN-1:0] mode_r;
  logic [CNT_W-1:0] thresh_r;
  logic [NUM_FUNC-1:0] kind_r;
  logic [NUM_FUNC-1:0] assign_r [NUM_IN];
  logic [NUM_FUNC-1:0] state_r, state_nxt;
  logic [NUM_FUNC-1:0] act_r;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r;

  // Event collection
  logic [NUM_IN-1:0] on_vec;
  logic [NUM_IN-1:0] off_vec;
  logic [NUM_IN-1:0] lvl_vec;
  logic [NUM_FUNC-1:0] on_any;
  logic [NUM_FUNC-1:0] off_any;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------

  // Word select from byte address
  wire [3:0] word = avs_address_in[5:2];
  wire [3:0] asg_off = word - tid_pkg::WORD_ASSIGN;
  wire sel_mode = word == tid_pkg::WORD_MODE;
  wire sel_thresh = word == tid_pkg::WORD_THRESH;
  wire sel_kind = word == tid_pkg::WORD_KIND;
  wire sel_status = word == tid_pkg::WORD_STATUS;
  wire sel_asg = (word >= tid_pkg::WORD_ASSIGN) && (32'(asg_off) < NUM_IN);

  // Handshake: one wait cycle, then the answer
  wire req = avs_read_in | avs_write_in;
  wire wr_take = avs_write_in & ack_r & ce_in;
  assign ack_nxt = req & ~ack_r;
  assign avs_waitrequest_out = ~ack_r;
  assign avs_readdata_out = rdata_r;

  // Status view
  wire [31:0] status_v = 32'({lvl_vec, state_r});

  // Assign word for the addressed input
  wire [NUM_FUNC-1:0] asg_sel_v = sel_asg ? assign_r[asg_off[2:0]] : '0;

  // Read mux; unmapped words read zero
  wire [31:0] rd_mux =
    sel_mode ? 32'(mode_r) :
    sel_thresh ? 32'(thresh_r) :
    sel_kind ? 32'(kind_r) :
    sel_status ? status_v :
    sel_asg ? 32'(asg_sel_v) :
    32'h0000_0000;

  // Write value honouring byte enables
  wire [31:0] wr_val = be_merge(rd_mux, avs_writedata_in, avs_byteenable_in);

  // Bus state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else if (ce_in) begin
      ack_r <= ack_nxt;
      if (avs_read_in && !ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------

  // Control types start as normal edge
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_r <= tid_pkg::MODE_RST[2*NUM_IN-1:0];
    end else if (wr_take && sel_mode) begin
      mode_r <= wr_val[2*NUM_IN-1:0];
    end
  end

  // Pulse threshold
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      thresh_r <= CNT_W'(ACCEPT_CYCLES);
    end else if (wr_take && sel_thresh) begin
      thresh_r <= clamp_thr(wr_val);
    end
  end

  // Single-action function mask
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      kind_r <= tid_pkg::KIND_RST[NUM_FUNC-1:0];
    end else if (wr_take && sel_kind) begin
      kind_r <= wr_val[NUM_FUNC-1:0];
    end
  end

  // Function sets per input
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_IN; i++) begin
        assign_r[i] <= tid_pkg::ASSIGN_RST[NUM_FUNC-1:0];
      end
    end else if (wr_take && sel_asg) begin
      assign_r[asg_off[2:0]] <= wr_val[NUM_FUNC-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Input decoders
  // ---------------------------------------------------------------
  for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_chan
    tid_chan_if #(.CNT_W(CNT_W)) cif ();

    // Per-input type and shared threshold
    assign cif.mode = tid_pkg::tid_mode_type'(mode_r[2*gi +: 2]);
    assign cif.thresh = thresh_r;
    assign on_vec[gi] = cif.on_evt;
    assign off_vec[gi] = cif.off_evt;
    assign lvl_vec[gi] = cif.level;

    tid_chan #(.CNT_W(CNT_W)) u_chan (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .pin_in(trig_in[gi]),
      .ch(cif.chan)
    );
  end

  // ---------------------------------------------------------------
  // Function core
  // ---------------------------------------------------------------

  // Fan each event out to every assigned function
  always_comb begin
    on_any = '0;
    off_any = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (on_vec[i]) begin
        on_any = on_any | assign_r[i];
      end
      if (off_vec[i]) begin
        off_any = off_any | assign_r[i];
      end
    end
  end

  // On wins over off; single-action functions hold no state
  assign state_nxt = (state_r | on_any) & ~(off_any & ~on_any) & ~kind_r;

  // Function outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= '0;
      act_r <= '0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      act_r <= on_any;
    end
  end

  assign func_state_out = state_r;
  assign func_act_out = act_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_bus_req;
    ce_in && req && avs_waitrequest_out;
  endsequence

  sequence s_any_on;
    ce_in && (on_any != '0);
  endsequence

  a_reset_normal_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(!rst_n_in) |-> mode_r == '0) else $error("mode not normal edge");
  a_on_sets_all: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_any_on |=> ((state_r | $past(kind_r)) & $past(on_any)) == $past(on_any))
    else $error("assigned function not on");
  a_single_no_state: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in |=> (state_r & $past(kind_r)) == '0) else $error("single function held");
  a_off_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && on_any == '0 && off_any != '0) |=> (state_r & $past(off_any)) == '0)
    else $error("off not applied");
  a_bus_answer: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_bus_req ##1 ce_in |-> !avs_waitrequest_out) else $error("bus answer late");

  // ---------------------------------------------------------------
  // Bus and configuration checks
  // ---------------------------------------------------------------

  // Band limits that a threshold write may leave behind
  wire [CNT_W-1:0] thr_lo = CNT_W'(tid_pkg::REJECT_CYC + tid_pkg::CLAMP_MARGIN);
  wire [CNT_W-1:0] thr_hi = CNT_W'(tid_pkg::DETECT_CYC - tid_pkg::CLAMP_MARGIN);

  // The answer stands for one cycle; no answer without a request
  a_answer_one_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !avs_waitrequest_out) |=> avs_waitrequest_out) else $error("answer held too long");
  a_idle_waits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !req) |=> avs_waitrequest_out) else $error("answer without request");

  // Read data is captured as the request is first seen
  a_read_captured: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && avs_read_in && avs_waitrequest_out) |=> avs_readdata_out == $past(rd_mux))
    else $error("read data not captured");

  // A full-word write lands unchanged in the type register
  a_mode_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_take && sel_mode && avs_byteenable_in == 4'hF) |=> mode_r == $past(avs_writedata_in[2*NUM_IN-1:0]))
    else $error("type write lost");

  // The low lane of a write sets the function mask of its input
  a_mask_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_take && sel_asg && avs_byteenable_in[0]) |=>
      assign_r[$past(asg_off[2:0])] == $past(avs_writedata_in[NUM_FUNC-1:0])) else $error("mask write lost");

  // Threshold writes never leave the band between the two widths
  a_thresh_band: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_take && sel_thresh) |=> thr_lo <= thresh_r && thresh_r <= thr_hi) else $error("threshold out of band");

  // ---------------------------------------------------------------
  // Function checks
  // ---------------------------------------------------------------

  // Commands seen by the left valve and the detector run function
  sequence s_load_cmd;
    ce_in && on_any[tid_pkg::FN_LEFT_INJECTION_VALVE] && !kind_r[tid_pkg::FN_LEFT_INJECTION_VALVE];
  endsequence

  sequence s_inject_cmd;
    ce_in && off_any[tid_pkg::FN_LEFT_INJECTION_VALVE] && !on_any[tid_pkg::FN_LEFT_INJECTION_VALVE];
  endsequence

  sequence s_start_cmd;
    ce_in && on_any[tid_pkg::FN_DETECTOR_RUN] && !kind_r[tid_pkg::FN_DETECTOR_RUN];
  endsequence

  sequence s_stop_cmd;
    ce_in && off_any[tid_pkg::FN_DETECTOR_RUN] && !on_any[tid_pkg::FN_DETECTOR_RUN];
  endsequence

  a_valve_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_load_cmd |=> func_state_out[tid_pkg::FN_LEFT_INJECTION_VALVE]) else $error("valve not in load");
  a_valve_inject: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_inject_cmd |=> !func_state_out[tid_pkg::FN_LEFT_INJECTION_VALVE]) else $error("valve not in inject");
  a_detector_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_start_cmd |=> func_state_out[tid_pkg::FN_DETECTOR_RUN]) else $error("detector not started");
  a_detector_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_stop_cmd |=> !func_state_out[tid_pkg::FN_DETECTOR_RUN]) else $error("detector not stopped");

  // Mark pulses only on its active edge
  a_mark_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && kind_r[tid_pkg::FN_DETECTOR_MARK]) |=>
      func_act_out[tid_pkg::FN_DETECTOR_MARK] == $past(on_any[tid_pkg::FN_DETECTOR_MARK]))
    else $error("mark acted on wrong edge");

  // An action pulse lasts one cycle unless a new event follows
  a_act_one_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && on_any == '0) |=> act_r == '0) else $error("action pulse stuck");

  // A low clock enable freezes functions and configuration alike
  a_ce_freeze: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ce_in |=> $stable(state_r) && $stable(act_r) && $stable(mode_r) && $stable(thresh_r))
    else $error("state moved while disabled");

endmodule

/* dv/tid_src_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Controlling instrument driving the trigger pins
// ---------------------------------------------------------------
module tid_src_model #(
  parameter int NUM_IN = 8,
  parameter int SHORT_CYC = 4,
  parameter int LONG_CYC = 50
) (
  input wire logic clk_in,
  output logic [NUM_IN-1:0] trig_out
);
  // Pins rest high until told otherwise
  initial begin
    trig_out = '1;
  end

  // Moves one pin just after a clock edge
  task automatic set_pin(input int i, input logic v);
    @(posedge clk_in);
    trig_out[i] <= v;
  endtask

  // Widths stay clear of the band where the device may go either way
  task automatic pulse(input int i, input logic act, input bit long_p);
    set_pin(i, act);
    repeat (long_p ? LONG_CYC : SHORT_CYC) @(posedge clk_in);
    trig_out[i] <= ~act;
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb_top;
  localparam int ACC = 20;
  logic clk_in;
  logic rst_n_in;
  logic ce;
  logic [7:0] trig;
  logic [5:0] addr;
  logic rd;
  logic wr;
  logic [3:0] be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [31:0] mode;
  logic [31:0] seed;
  logic wreq;
  logic [7:0] st;
  logic [7:0] act;
  logic [7:0] act_seen;
  logic [7:0] exp_st;
  logic [7:0] kind;
  logic [7:0] m [4];
  logic lvl;
  int p [4];
  int n_mismatch;
  int samples_checked;
  int cyc;

  // ---------------------------------------------------------------
  // Design, instrument model, clock and watchdog
  // ---------------------------------------------------------------
  tid_top #(.ACCEPT_CYCLES(ACC)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .trig_in(trig),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .func_state_out(st), .func_act_out(act));
  tid_src_model src (.clk_in(clk_in), .trig_out(trig));

  initial begin
    clk_in = 1'b0;
    cyc = 0;
    forever #4 clk_in = ~clk_in;
  end

  // Collects every action pulse since the last clear
  always @(posedge clk_in) begin
    act_seen <= act_seen | act;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] dt, input logic [3:0] bm,
                     output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge clk_in);
    rd <= ~w;
    wr <= w;
    addr <= ad;
    wdata <= dt;
    be <= bm;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    rq = rdata;
    if (n >= 100) n_mismatch++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Level change (pw 0) or pulse (1 short, 2 long); op 0 none, 1 on, 2 off
  task automatic ev(input int i, input logic v, input int op, input logic [7:0] mk, input int pw);
    @(negedge clk_in);
    act_seen = 8'h00;
    if (pw == 0) src.set_pin(i, v);
    else src.pulse(i, v, pw == 2);
    repeat (8) @(posedge clk_in);
    if (op == 1) exp_st = exp_st | (mk & ~kind);
    if (op == 2) exp_st = exp_st & ~(mk & ~kind);
    `CHK("act", (op == 1) ? mk : 8'h00, act_seen)
    `CHK("state", exp_st, st)
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h0000_21CB;
    ce = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 6'h00;
    wdata = 32'h0000_0000;
    be = 4'hF;
    rst_n_in = 1'b0;
    exp_st = 8'h00;
    kind = 8'hC0;
    act_seen = 8'h00;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // Reset values, lane merge and an unmapped word
    bus(1'b0, 6'h00, 32'h0, 4'hF, q);
    `CHK("mode", 32'h0000_0000, q)
    bus(1'b0, 6'h04, 32'h0, 4'hF, q);
    `CHK("thresh", 32'(ACC), q)
    bus(1'b1, 6'h08, 32'h0000_0000, 4'h2, q);
    bus(1'b0, 6'h08, 32'h0, 4'hF, q);
    `CHK("kind", 32'h0000_00C0, q)
    bus(1'b1, 6'h30, 32'hFFFF_FFFF, 4'hF, q);
    bus(1'b0, 6'h30, 32'h0, 4'hF, q);
    `CHK("unmapped", 32'h0000_0000, q)
    $display("test registers done");
    // Four inputs, one of each control type, random masks with a valve and the detector
    seed = xs(seed);
    mode = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      p[k] = (int'(seed[2:0]) + k) % 8;
      m[k] = seed[8*k +: 8] | 8'h61;
      mode[2*p[k] +: 2] = 2'(k);
      bus(1'b1, 6'(16 + 4 * p[k]), {24'h0, m[k]}, 4'hF, q);
    end
    bus(1'b1, 6'h00, mode, 4'hF, q);
    bus(1'b0, 6'h00, 32'h0, 4'hF, q);
    `CHK("mode_rb", mode, q)
    ev(p[0], 1'b0, 1, m[0], 0);
    ev(p[0], 1'b1, 2, m[0], 0);
    for (int n = 0; n < 10; n++) begin
      seed = xs(seed);
      lvl = seed[0];
      if (lvl !== trig[p[0]]) ev(p[0], lvl, lvl ? 2 : 1, m[0], 0);
    end
    if (trig[p[0]] !== 1'b1) ev(p[0], 1'b1, 2, m[0], 0);
    $display("test normal edge done");
    // Clock enable low holds the decoder; the edge acts once it returns
    @(negedge clk_in);
    act_seen = 8'h00;
    @(posedge clk_in);
    ce <= 1'b0;
    src.set_pin(p[0], 1'b0);
    repeat (8) @(posedge clk_in);
    `CHK("frozen_act", 8'h00, act_seen)
    `CHK("frozen_state", exp_st, st)
    ce <= 1'b1;
    ev(p[0], 1'b0, 1, m[0], 0);
    ev(p[0], 1'b1, 2, m[0], 0);
    $display("test clock enable done");
    ev(p[1], 1'b0, 2, m[1], 0);
    ev(p[1], 1'b1, 1, m[1], 0);
    $display("test inverted edge done");
    ev(p[2], 1'b0, 0, m[2], 1);
    ev(p[2], 1'b0, 1, m[2], 2);
    $display("test normal pulse done");
    ev(p[3], 1'b0, 0, m[3], 0);
    ev(p[3], 1'b1, 0, m[3], 1);
    ev(p[3], 1'b1, 1, m[3], 2);
    $display("test inverted pulse done");
    bus(1'b0, 6'h0C, 32'h0, 4'hF, q);
    `CHK("status_func", exp_st, q[7:0])
    `CHK("status_pins", trig, q[15:8])
    $display("test status done");
    // Reset in mid-run restores defaults; threshold writes are clamped to the band
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    exp_st = 8'h00;
    bus(1'b0, 6'h00, 32'h0, 4'hF, q);
    `CHK("mode_reset", 32'h0000_0000, q)
    `CHK("state_reset", exp_st, st)
    bus(1'b1, 6'h04, 32'h0000_0000, 4'hF, q);
    bus(1'b0, 6'h04, 32'h0, 4'hF, q);
    `CHK("thresh_lo", 32'(tid_pkg::REJECT_CYC + tid_pkg::CLAMP_MARGIN), q)
    bus(1'b1, 6'h04, 32'hFFFF_FFFF, 4'hF, q);
    bus(1'b0, 6'h04, 32'h0, 4'hF, q);
    `CHK("thresh_hi", 32'(tid_pkg::DETECT_CYC - tid_pkg::CLAMP_MARGIN), q)
    $display("test reset and clamp done");
    final_report();
  end
endmodule
